// File: eeprom_pkg.sv
// shared constants, types and timing for the two-wire serial memory slave
package eeprom_pkg;

  // ==========================================================================
  // clock and programming times
  localparam int CLK_MHZ        = 40;
  localparam int PROG_TYP_US    = 10000;
  localparam int PROG_MAX_US    = 20000;
  localparam int TOTAL_ERASE_US = 20000;
  // typical cycle split evenly into erase and write phases
  localparam int PHASE_CYCLES   = (PROG_TYP_US * CLK_MHZ) / 2;
  localparam int PROG_MAX_CYCLES = PROG_MAX_US * CLK_MHZ;
  localparam int TOTAL_CYCLES   = TOTAL_ERASE_US * CLK_MHZ;
  localparam int TIMER_W        = 20;

  // ==========================================================================
  // array and byte layout
  localparam int         ADDR_W        = 7;
  localparam int         DATA_W        = 8;
  localparam int         WORDS         = 128;
  localparam logic [6:0] ADDR_TOP      = 7'h7f;
  localparam logic [6:0] ADDR_RESET    = 7'h00;
  localparam logic [6:0] TOTAL_ADDR    = 7'h00;
  localparam logic [7:0] ERASED_WORD   = 8'hff;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [3:0] CNT_RESET     = 4'h0;
  localparam logic [3:0] CNT_LAST_BIT  = 4'h7;
  localparam logic [3:0] CNT_BYTE_DONE = 4'h8;
  localparam logic [3:0] CNT_ACK_DONE  = 4'h9;
  // device type prefix: value is arbitrary
  localparam logic [3:0] DEVICE_TYPE   = 4'h6;
  localparam logic       DIR_WRITE     = 1'b0;
  localparam logic       DIR_READ      = 1'b1;
  localparam logic       OD_LOW        = 1'b0;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_ADDR, ST_DATA, ST_READ, ST_IGNORE} bus_state_e;
  typedef enum logic [1:0] {PG_IDLE, PG_ERASE, PG_WRITE} prog_state_e;

  typedef struct packed {
    logic       total;
    logic [6:0] addr;
    logic [7:0] data;
  } prog_req_s;

  localparam prog_req_s REQ_RESET = '{total: 1'b0, addr: 7'h00, data: 8'h00};

endpackage : eeprom_pkg

// File: serial_eeprom_i2c_slave.sv
// two-wire slave front end, sequence control and programming engine of a 128 x 8 memory
// Behaviour
// [R1] start and stop detected at any time
// [R2] sample sda on scl high, change on low
// [R3] ack low from eighth fall through ninth
// [R4] release sda during ninth clock when reading
// [R5] master sends select, address, data bytes
// [R6] master clocks nine per read byte
// [R7] programming starts only at the stop
// [R8] respond only when select bits match straps
// [R9] write select during programming aborts it
// [R10] read select ignored while programming
// [R11] read uses address write, restart, read select
// [R12] load word at ninth, drive first bit
// [R13] shift bits, increment on master ack low
// [R14] address counter never wraps past top
// [R15] stop releases sda and returns to idle
// [R16] erase word to ones, then write zeros
// [R17] programming time typical 10, max 20 ms
// [R18] all-ones data skips write phase
// [R19] already erased word skips erase phase
// [R20] power-on lockout rejects programming requests
// [R21] address 0, data ff, strap open: total erase
// [R22] select byte: type, three straps, direction
// [R23] address byte: zero then seven bits
// [R24] third byte is the data word
// [R25] oversample lines, edges make bus events
// [R26] programming length set by parameters
`timescale 1ns/1ps

module serial_eeprom_i2c_slave #(
  parameter int ERASE_CYCLES       = eeprom_pkg::PHASE_CYCLES,
  parameter int WRITE_CYCLES       = eeprom_pkg::PHASE_CYCLES,
  parameter int TOTAL_ERASE_CYCLES = eeprom_pkg::TOTAL_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // serial bus, sda is open drain
  input  wire logic scl,
  input  wire logic sda_in,
  output wire logic sda_out,
  output logic      sda_oe,
  // straps
  input  wire logic select_strap_low,
  input  wire logic select_strap_mid,
  input  wire logic select_strap_high_erase,
  input  wire logic total_erase_open,
  // status
  output wire logic prog_busy,
  output logic      power_on_lockout
);

  // local views of the package types and their members
  typedef eeprom_pkg::bus_state_e  bus_state_e;
  typedef eeprom_pkg::prog_state_e prog_state_e;
  typedef eeprom_pkg::prog_req_s   prog_req_s;
  localparam bus_state_e  ST_IDLE   = eeprom_pkg::ST_IDLE;
  localparam bus_state_e  ST_SEL    = eeprom_pkg::ST_SEL;
  localparam bus_state_e  ST_ADDR   = eeprom_pkg::ST_ADDR;
  localparam bus_state_e  ST_DATA   = eeprom_pkg::ST_DATA;
  localparam bus_state_e  ST_READ   = eeprom_pkg::ST_READ;
  localparam bus_state_e  ST_IGNORE = eeprom_pkg::ST_IGNORE;
  localparam prog_state_e PG_IDLE   = eeprom_pkg::PG_IDLE;
  localparam prog_state_e PG_ERASE  = eeprom_pkg::PG_ERASE;
  localparam prog_state_e PG_WRITE  = eeprom_pkg::PG_WRITE;

  // ==========================================================================
  // synchronisers and bus events
  logic [1:0] scl_sync, sda_sync;
  logic [3:0] strap_meta, strap_sync;
  logic       scl_d, sda_d;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync   <= 2'h3;
      sda_sync   <= 2'h3;
      strap_meta <= 4'h0;
      strap_sync <= 4'h0;
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
    end else begin
      scl_sync   <= {scl_sync[0], scl}; // R25
      sda_sync   <= {sda_sync[0], sda_in};
      strap_meta <= {total_erase_open, select_strap_high_erase, select_strap_mid,
                     select_strap_low};
      strap_sync <= strap_meta;
      scl_d      <= scl_sync[1];
      sda_d      <= sda_sync[1];
    end
  end

  wire logic scl_s     = scl_sync[1];
  wire logic sda_s     = sda_sync[1];
  wire logic scl_rise  = scl_s & ~scl_d;
  wire logic scl_fall  = ~scl_s & scl_d;
  // scl stable high across the sda edge
  wire logic bus_start = scl_s & scl_d & sda_d & ~sda_s; // R1
  wire logic bus_stop  = scl_s & scl_d & ~sda_d & sda_s; // R1
  wire logic erase_open = strap_sync[3];

  // ==========================================================================
  // byte decode
  bus_state_e            state;
  logic [3:0]            cnt;
  logic [7:0]            shreg, out_reg;
  logic [6:0]            word_address_byte;
  logic [7:0]            write_data_byte;
  logic                  armed, master_ack;
  logic [7:0]            mem [eeprom_pkg::WORDS];
  prog_state_e           pstate;
  logic                  push_ready, pop_valid;

  wire logic       byte_done = scl_fall && cnt == eeprom_pkg::CNT_BYTE_DONE;
  wire logic       ack_end   = scl_fall && cnt == eeprom_pkg::CNT_ACK_DONE;
  wire logic       sel_match = shreg[7:4] == eeprom_pkg::DEVICE_TYPE &&
                               shreg[3:1] == strap_sync[2:0]; // R8 R22
  wire logic       write_sel = state == ST_SEL && byte_done && sel_match &&
                               shreg[0] == eeprom_pkg::DIR_WRITE;
  wire logic       read_sel  = state == ST_SEL && byte_done && sel_match &&
                               shreg[0] == eeprom_pkg::DIR_READ && !prog_busy; // R10
  wire logic       abort     = write_sel && prog_busy; // R9
  wire logic       at_top    = word_address_byte == eeprom_pkg::ADDR_TOP;
  wire logic [6:0] next_addr = at_top ? word_address_byte : word_address_byte + 7'h01; // R14
  wire logic [7:0] next_word = mem[next_addr];
  wire logic       total_req = word_address_byte == eeprom_pkg::TOTAL_ADDR &&
                               write_data_byte == eeprom_pkg::ERASED_WORD && erase_open;
  wire logic       push      = bus_stop && armed && !power_on_lockout && push_ready; // R7 R20

  assign sda_out = eeprom_pkg::OD_LOW;

  // bit counter and receive shifter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= eeprom_pkg::CNT_RESET;
      shreg <= eeprom_pkg::BYTE_RESET;
    end else if (bus_start || bus_stop) begin
      cnt <= eeprom_pkg::CNT_RESET;
    end else if (scl_rise) begin
      if (cnt < eeprom_pkg::CNT_BYTE_DONE) begin
        shreg <= {shreg[6:0], sda_s}; // R2
      end
      if (cnt < eeprom_pkg::CNT_ACK_DONE) begin
        cnt <= cnt + 4'h1;
      end
    end else if (ack_end) begin
      cnt <= eeprom_pkg::CNT_RESET;
    end
  end

  // sequence control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (bus_stop) begin
      state <= ST_IDLE; // R15
    end else if (bus_start) begin
      state <= ST_SEL; // R11
    end else if (byte_done) begin
      case (state)
        ST_SEL:  state <= write_sel ? ST_ADDR : (read_sel ? ST_SEL : ST_IGNORE); // R5
        ST_ADDR: state <= ST_DATA;
        ST_DATA: state <= ST_IGNORE;
        default: state <= state;
      endcase
    end else if (ack_end) begin
      case (state)
        ST_SEL:  state <= ST_READ; // R12
        ST_READ: state <= master_ack ? ST_IGNORE : ST_READ;
        default: state <= state;
      endcase
    end
  end

  // address, data and arming of a program request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_address_byte <= eeprom_pkg::ADDR_RESET;
      write_data_byte   <= eeprom_pkg::BYTE_RESET;
      armed             <= 1'b0;
    end else if (bus_start || bus_stop) begin
      armed <= 1'b0;
    end else if (byte_done && state == ST_ADDR) begin
      word_address_byte <= shreg[6:0]; // R23
    end else if (byte_done && state == ST_DATA) begin
      write_data_byte <= shreg; // R24
      armed           <= push_ready;
    end else if (ack_end && state == ST_READ && !master_ack) begin
      word_address_byte <= next_addr; // R13 R14
    end
  end

  // master acknowledge sampled on the ninth rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_ack <= 1'b1;
    end else if (scl_rise && state == ST_READ && cnt == eeprom_pkg::CNT_BYTE_DONE) begin
      master_ack <= sda_s; // R13
    end
  end

  // sda drive and read shifter; drive only changes after a falling scl edge or at a start or stop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe  <= 1'b0; // R20
      out_reg <= eeprom_pkg::BYTE_RESET;
    end else if (bus_start || bus_stop) begin
      sda_oe <= 1'b0; // R15
    end else if (byte_done) begin
      case (state)
        ST_SEL:  sda_oe <= write_sel || read_sel; // R3 R8 R10
        ST_ADDR: sda_oe <= 1'b1; // R3
        ST_DATA: sda_oe <= push_ready; // R3
        default: sda_oe <= 1'b0; // R4
      endcase
      if (read_sel) begin
        out_reg <= mem[word_address_byte]; // R12
      end
    end else if (ack_end) begin
      if (state == ST_SEL && sda_oe) begin
        sda_oe  <= ~out_reg[7]; // R12
        out_reg <= {out_reg[6:0], 1'b1};
      end else if (state == ST_READ && !master_ack) begin
        sda_oe  <= ~next_word[7]; // R13
        out_reg <= {next_word[6:0], 1'b1};
      end else begin
        sda_oe <= 1'b0;
      end
    end else if (scl_fall && state == ST_READ && cnt != eeprom_pkg::CNT_RESET &&
                 cnt <= eeprom_pkg::CNT_LAST_BIT) begin
      sda_oe  <= ~out_reg[7]; // R13
      out_reg <= {out_reg[6:0], 1'b1};
    end
  end

  // power-on lockout, lifted by the first acknowledged read select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_on_lockout <= 1'b1;
    end else if (read_sel) begin
      power_on_lockout <= 1'b0; // R20
    end
  end

  // ==========================================================================
  // two-entry request buffer; a full buffer withholds the data byte ack
  prog_req_s slot [2];
  logic      wr_ptr, rd_ptr;
  logic [1:0] fill;
  wire logic pop = pop_valid && pstate == PG_IDLE && !abort;

  assign push_ready = fill != 2'h2;
  assign pop_valid  = fill != 2'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot[0] <= eeprom_pkg::REQ_RESET;
      slot[1] <= eeprom_pkg::REQ_RESET;
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      fill    <= 2'h0;
    end else if (abort) begin
      rd_ptr <= wr_ptr; // R9
      fill   <= 2'h0;
    end else begin
      if (push) begin
        slot[wr_ptr] <= '{total: total_req, addr: word_address_byte,
                           data: write_data_byte}; // R21
        wr_ptr       <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  // ==========================================================================
  // programming engine with on-chip timing
  prog_req_s         cur;
  logic [eeprom_pkg::TIMER_W-1:0] timer;
  prog_req_s         head;
  wire logic         done       = timer == '0;
  wire logic         erase_done = pstate == PG_ERASE && done && !abort;
  wire logic         write_done = pstate == PG_WRITE && done && !abort;

  assign head      = slot[rd_ptr];
  assign prog_busy = pstate != PG_IDLE || pop_valid;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate <= PG_IDLE;
      timer  <= '0;
      cur    <= eeprom_pkg::REQ_RESET;
    end else if (abort) begin
      pstate <= PG_IDLE; // R9
    end else begin
      case (pstate)
        PG_IDLE: if (pop) begin
          cur <= head;
          if (head.total) begin
            pstate <= PG_ERASE; // R21
            timer  <= eeprom_pkg::TIMER_W'(TOTAL_ERASE_CYCLES - 1);
          end else if (mem[head.addr] != eeprom_pkg::ERASED_WORD) begin
            pstate <= PG_ERASE; // R16 R26
            timer  <= eeprom_pkg::TIMER_W'(ERASE_CYCLES - 1);
          end else if (head.data != eeprom_pkg::ERASED_WORD) begin
            pstate <= PG_WRITE; // R19
            timer  <= eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1);
          end
        end
        PG_ERASE: if (done) begin
          if (cur.total || cur.data == eeprom_pkg::ERASED_WORD) begin
            pstate <= PG_IDLE; // R18
          end else begin
            pstate <= PG_WRITE; // R16 R17
            timer  <= eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1);
          end
        end else begin
          timer <= timer - 1'b1;
        end
        PG_WRITE: if (done) begin
          pstate <= PG_IDLE;
        end else begin
          timer <= timer - 1'b1;
        end
        default: pstate <= PG_IDLE;
      endcase
    end
  end

  // array: erase sets ones, write clears the zero bits of the data word
  always_ff @(posedge sys_clk) begin
    if (erase_done) begin
      if (cur.total) begin
        for (int i = 0; i < eeprom_pkg::WORDS; i++) begin
          mem[i] <= eeprom_pkg::ERASED_WORD; // R21
        end
      end else begin
        mem[cur.addr] <= eeprom_pkg::ERASED_WORD; // R16
      end
    end else if (write_done) begin
      mem[cur.addr] <= mem[cur.addr] & cur.data; // R16
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  start_resets_seq_a: assert property (bus_start && !bus_stop |=> state == ST_SEL && cnt == 4'h0) // R1
    else $error("start did not reset the sequence");
  addr_ack_low_a: assert property (byte_done && state == ST_ADDR && !bus_start && !bus_stop
    |=> sda_oe) // R3
    else $error("address byte not acknowledged");
  read_ack_release_a: assert property (byte_done && state == ST_READ && !bus_stop
    |=> !sda_oe) // R4
    else $error("sda driven during master acknowledge");
  mismatch_no_ack_a: assert property (state == ST_SEL && byte_done && !sel_match |=> !sda_oe) // R8
    else $error("acknowledged a foreign select");
  busy_read_ignored_a: assert property (state == ST_SEL && byte_done && prog_busy &&
    shreg[0] == eeprom_pkg::DIR_READ |=> !sda_oe) // R10
    else $error("read select acknowledged while programming");
  write_sel_abort_a: assert property (abort |=> pstate == PG_IDLE && fill == 2'h0) // R9
    else $error("programming not aborted");
  stop_to_idle_a: assert property (bus_stop |=> state == ST_IDLE && !sda_oe) // R15
    else $error("stop did not release the bus");
  top_no_wrap_a: assert property (at_top && ack_end && state == ST_READ && !master_ack
    |=> word_address_byte == eeprom_pkg::ADDR_TOP) // R14
    else $error("read address wrapped");
  lockout_no_push_a: assert property (power_on_lockout && bus_stop && armed && !pop
    |=> fill == $past(fill)) // R20
    else $error("program request taken during lockout");
  stop_starts_prog_a: assert property (push && !pop |=> fill == $past(fill) + 2'h1) // R7
    else $error("stop did not queue programming");
  ones_skip_write_a: assert property (pstate == PG_ERASE && done && !abort &&
    cur.data == eeprom_pkg::ERASED_WORD |=> pstate == PG_IDLE) // R18
    else $error("write phase not skipped");

  write_seq_c: cover property (push);
  read_seq_c: cover property (ack_end && state == ST_READ && !master_ack);
  abort_seq_c: cover property (abort);
  total_erase_c: cover property (erase_done && cur.total);

endmodule : serial_eeprom_i2c_slave

// File: bus_master_model.sv
// two-wire bus master model: drives the bus clock and pulls the open-drain data line
`timescale 1ns/1ps

module bus_master_model (
  // resolved data line
  input  wire logic sda,
  // driven lines
  output logic      scl,
  output logic      sda_low
);
  // ==========================================================================
  // idle bus: clock stands high, data released to the pull-up
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ==========================================================================
  // bit level
  // low phase is long and high phase short: the slave's synchronised ack release
  // must land before the next rise or it would look like a stop
  task automatic bit_cycle(input logic b, output logic s);
    #20 sda_low = !b;
    #110 scl = 1'b1;
    #60 s = sda;
    #10 scl = 1'b0;
  endtask : bit_cycle

  task automatic start();
    sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask : start

  task automatic restart();
    #20 sda_low = 1'b0;
    #110 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask : restart

  task automatic stop();
    #20 sda_low = 1'b1;
    #110 scl = 1'b1;
    #100 sda_low = 1'b0;
    #200;
  endtask : stop

  // ==========================================================================
  // byte level, msb first, ninth clock returns or gives the ack level
  task automatic send_byte(input logic [7:0] d, output logic ack_line);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, ack_line);
  endtask : send_byte

  task automatic recv_byte(input logic ack_line, output logic [7:0] d, output logic nine);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(ack_line, nine);
  endtask : recv_byte
endmodule : bus_master_model

// File: testbench.sv
// self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps

module testbench;
  localparam logic [2:0] STRAPS = 3'b101;

  logic       sys_clk;
  logic       rst_n;
  logic [2:0] straps;
  logic       total_erase_open;
  wire logic  scl;
  wire logic  sda;
  wire logic  m_low;
  wire logic  sda_oe;
  wire logic  prog_busy;
  wire logic  lockout;
  int         fail_count;
  int         n_compared;
  int         n;

  // open drain with pull-up
  assign sda = !(sda_oe | m_low);

  serial_eeprom_i2c_slave #(
    .ERASE_CYCLES       (400),
    .WRITE_CYCLES       (400),
    .TOTAL_ERASE_CYCLES (800)
  ) DUT (
    .sys_clk                 (sys_clk),
    .rst_n                   (rst_n),
    .scl                     (scl),
    .sda_in                  (sda),
    .sda_out                 (),
    .sda_oe                  (sda_oe),
    .select_strap_low        (straps[0]),
    .select_strap_mid        (straps[1]),
    .select_strap_high_erase (straps[2]),
    .total_erase_open        (total_erase_open),
    .prog_busy               (prog_busy),
    .power_on_lockout        (lockout)
  );

  bus_master_model m (.sda(sda), .scl(scl), .sda_low(m_low));

  always #12.5 sys_clk = !sys_clk;

  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [7:0] sel(input logic dir);
    return {eeprom_pkg::DEVICE_TYPE, STRAPS, dir};
  endfunction : sel

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic k;
    m.start();
    m.send_byte(sel(eeprom_pkg::DIR_WRITE), k);
    check(8'(k), 8'h00);
    m.send_byte({1'b0, a}, k);
    check(8'(k), 8'h00);
    m.send_byte(d, k);
    check(8'(k), 8'h00);
    check(8'(prog_busy), 8'h00);
    m.stop();
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e0, input logic [7:0] e1,
                    input logic chk);
    logic       k;
    logic       n9;
    logic [7:0] d;
    m.start();
    m.send_byte(sel(eeprom_pkg::DIR_WRITE), k);
    check(8'(k), 8'h00);
    m.send_byte({1'b0, a}, k);
    check(8'(k), 8'h00);
    m.restart();
    m.send_byte(sel(eeprom_pkg::DIR_READ), k);
    check(8'(k), 8'h00);
    m.recv_byte(1'b0, d, n9);
    if (chk) check(d, e0);
    m.recv_byte(1'b1, d, n9);
    if (chk) check(d, e1);
    check(8'(n9), 8'h01);
    m.stop();
    check(8'(sda_oe), 8'h00);
  endtask : rd

  task automatic poll(input logic exp);
    logic       k;
    logic       n9;
    logic [7:0] d;
    m.start();
    m.send_byte(sel(eeprom_pkg::DIR_READ), k);
    check(8'(k), 8'(exp));
    if (k === 1'b0) m.recv_byte(1'b1, d, n9);
    m.stop();
  endtask : poll

  // bounded wait for the programming engine, counts the busy cycles
  task automatic wait_idle();
    n = 0;
    while (prog_busy === 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 5000) begin
      fail_count++;
      $display("MISMATCH t=%0t busy wait expired", $time);
    end
  endtask : wait_idle

  // ==========================================================================
  // watchdog
  initial begin
    #2ms;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    sys_clk          = 1'b0;
    rst_n            = 1'b0;
    straps           = STRAPS;
    total_erase_open = 1'b0;
    fail_count       = 0;
    n_compared       = 0;
    repeat (5) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    check({5'h00, sda_oe, prog_busy, lockout}, 8'h01);
    repeat (4) @(posedge sys_clk);
    wr(7'h03, 8'h00);
    check(8'(prog_busy), 8'h00);
    rd(7'h00, 8'h00, 8'h00, 1'b0);
    check(8'(lockout), 8'h00);
    @(posedge sys_clk);
    #2 total_erase_open = 1'b1;
    wr(eeprom_pkg::TOTAL_ADDR, eeprom_pkg::ERASED_WORD);
    @(posedge sys_clk);
    #2 total_erase_open = 1'b0;
    check(8'(prog_busy), 8'h01);
    wait_idle();
    check(8'(n > 700), 8'h01);
    // erased word: erase skipped, poll refused meanwhile
    wr(7'h05, 8'ha5);
    poll(1'b1);
    wait_idle();
    check(8'(n < 400), 8'h01);
    poll(1'b0);
    wr(7'h05, 8'h5a);
    wait_idle();
    check(8'(n > 700), 8'h01);
    wr(7'h09, 8'hff);
    wait_idle();
    check(8'(n < 20), 8'h01);
    wr(7'h7f, 8'h81);
    wait_idle();
    wr(7'h00, 8'h3c);
    wait_idle();
    rd(7'h04, 8'hff, 8'h5a, 1'b1);
    rd(7'h7f, 8'h81, 8'h81, 1'b1);
    // write select in mid-programming aborts
    wr(7'h09, 8'h00);
    m.start();
    m.send_byte(sel(eeprom_pkg::DIR_WRITE), n[0]);
    check(8'(n[0]), 8'h00);
    repeat (8) @(posedge sys_clk);
    check(8'(prog_busy), 8'h00);
    m.stop();
    rd(7'h09, 8'hff, 8'hff, 1'b1);
    // strap mismatch is not acknowledged
    @(posedge sys_clk);
    #2 straps = 3'b100;
    repeat (4) @(posedge sys_clk);
    m.start();
    m.send_byte(sel(eeprom_pkg::DIR_WRITE), n[0]);
    check(8'(n[0]), 8'h01);
    m.stop();
    end_of_test();
  end
endmodule : testbench
